// file: software_lcd_pin_driver.v
// software lcd pin driver with axi4-lite register slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lcd_pin_map.vh"

module software_lcd_pin_driver (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [4:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [4:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // analog pin switch controls
   output reg [59:0] pin_level_sel_ff,
   output reg [29:0] pin_lcd_active_ff,
   output reg bias_divider_on_ff,
   output reg [1:0] bias_current_code_ff
);

   reg [7:0] phase_bias_ff;
   reg [7:0] common_role_ff;
   reg [7:0] seg_en_low_ff;
   reg [7:0] seg_en_mid_ff;
   reg [7:0] seg_en_high_ff;
   reg [15:0] port_data_lo_ff;
   reg [13:0] port_data_hi_ff;
   reg osc_claim_ff;
   reg [4:0] aw_addr_ff;
   reg aw_have_ff;
   reg [15:0] w_data_ff;
   reg [1:0] w_strb_ff;
   reg w_have_ff;

   wire [29:0] port_data;
   wire master_on;
   wire phase;
   wire [29:0] pin_sel;
   wire [5:0] is_segment;
   reg [59:0] nxt_level;
   reg [7:0] rd_byte;
   reg rd_hit;
   reg wr_hit;
   integer i;

   assign port_data = {port_data_hi_ff, port_data_lo_ff};
   assign master_on = phase_bias_ff[`MASTER_ON_BIT];
   assign phase = phase_bias_ff[`PHASE_BIT];
   // per-pin lcd function selection; no direction register is consulted
   assign pin_sel = {seg_en_high_ff,
                     seg_en_mid_ff[7:2],
                     seg_en_mid_ff[1:0] & {2{~osc_claim_ff}},
                     seg_en_low_ff,
                     common_role_ff[7:6],
                     phase_bias_ff[3:0]};
   assign is_segment = common_role_ff[5:0];

   // level choice per pin from phase and data bit
   always @* begin
      nxt_level = {60{1'b0}};
      for (i = 0; i < `PIN_COUNT; i = i + 1) begin
         if (!master_on || !pin_sel[i]) begin
            nxt_level[2*i +: 2] = `LVL_GND;
         end else if ((i < 6) && !is_segment[i]) begin
            // common pin: phase gives polarity, data bit selects rail or bias level
            if (!phase) begin
               nxt_level[2*i +: 2] = port_data[i] ? `LVL_SUPPLY : `LVL_LOW_BIAS;
            end else begin
               nxt_level[2*i +: 2] = port_data[i] ? `LVL_GND : `LVL_HIGH_BIAS;
            end
         end else begin
            if (!phase) begin
               nxt_level[2*i +: 2] = port_data[i] ? `LVL_GND : `LVL_HIGH_BIAS;
            end else begin
               nxt_level[2*i +: 2] = port_data[i] ? `LVL_SUPPLY : `LVL_LOW_BIAS;
            end
         end
      end
   end

   // registered analog controls
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_level_sel_ff <= {60{1'b0}};
         pin_lcd_active_ff <= {30{1'b0}};
         bias_divider_on_ff <= 1'b0;
         bias_current_code_ff <= 2'b00;
      end else begin
         pin_level_sel_ff <= nxt_level;
         pin_lcd_active_ff <= pin_sel & {30{master_on}};
         bias_divider_on_ff <= master_on;
         bias_current_code_ff <= phase_bias_ff[`BIAS_HI_BIT:`BIAS_LO_BIT];
      end
   end

   // write address decode
   always @* begin
      case (aw_addr_ff)
         `PHASE_BIAS_OFS, `COMMON_ROLE_OFS, `SEG_EN_LOW_OFS, `SEG_EN_MID_OFS,
         `SEG_EN_HIGH_OFS, `PORT_DATA_LO_OFS, `PORT_DATA_HI_OFS,
         `OSC_CLAIM_OFS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // axi4-lite write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= 5'h00;
         w_data_ff <= 16'h0000;
         w_strb_ff <= 2'b00;
         phase_bias_ff <= `REG_RESET;
         common_role_ff <= `REG_RESET;
         seg_en_low_ff <= `REG_RESET;
         seg_en_mid_ff <= `REG_RESET;
         seg_en_high_ff <= `REG_RESET;
         port_data_lo_ff <= 16'h0000;
         port_data_hi_ff <= 14'h0000;
         osc_claim_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_ff <= {s_axi_awaddr[4:2], 2'b00};
            aw_have_ff <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_ff <= s_axi_wdata[15:0];
            w_strb_ff <= s_axi_wstrb[1:0];
            w_have_ff <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            if (w_strb_ff[0]) begin
               case (aw_addr_ff)
                  `PHASE_BIAS_OFS: phase_bias_ff <= w_data_ff[7:0];
                  `COMMON_ROLE_OFS: common_role_ff <= w_data_ff[7:0];
                  `SEG_EN_LOW_OFS: seg_en_low_ff <= w_data_ff[7:0];
                  `SEG_EN_MID_OFS: seg_en_mid_ff <= w_data_ff[7:0];
                  `SEG_EN_HIGH_OFS: seg_en_high_ff <= w_data_ff[7:0];
                  `PORT_DATA_LO_OFS: port_data_lo_ff[7:0] <= w_data_ff[7:0];
                  `PORT_DATA_HI_OFS: port_data_hi_ff[7:0] <= w_data_ff[7:0];
                  `OSC_CLAIM_OFS: osc_claim_ff <= w_data_ff[0];
                  default: osc_claim_ff <= osc_claim_ff;
               endcase
            end
            // upper port data bytes come with byte lane 1
            if (w_strb_ff[1]) begin
               if (aw_addr_ff == `PORT_DATA_LO_OFS) begin
                  port_data_lo_ff[15:8] <= w_data_ff[15:8];
               end
               if (aw_addr_ff == `PORT_DATA_HI_OFS) begin
                  port_data_hi_ff[13:8] <= w_data_ff[13:8];
               end
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read address decode
   always @* begin
      rd_hit = 1'b1;
      rd_byte = 8'h00;
      case ({s_axi_araddr[4:2], 2'b00})
         `PHASE_BIAS_OFS: rd_byte = phase_bias_ff;
         `COMMON_ROLE_OFS: rd_byte = common_role_ff;
         `SEG_EN_LOW_OFS: rd_byte = seg_en_low_ff;
         `SEG_EN_MID_OFS: rd_byte = seg_en_mid_ff;
         `SEG_EN_HIGH_OFS: rd_byte = seg_en_high_ff;
         `PORT_DATA_LO_OFS: rd_byte = port_data_lo_ff[7:0];
         `PORT_DATA_HI_OFS: rd_byte = port_data_hi_ff[7:0];
         `OSC_CLAIM_OFS: rd_byte = {7'h00, osc_claim_ff};
         default: rd_hit = 1'b0;
      endcase
   end

   // axi4-lite read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         if ({s_axi_araddr[4:2], 2'b00} == `PORT_DATA_LO_OFS) begin
            s_axi_rdata <= {16'h0000, port_data_lo_ff};
         end else if ({s_axi_araddr[4:2], 2'b00} == `PORT_DATA_HI_OFS) begin
            s_axi_rdata <= {18'h00000, port_data_hi_ff};
         end else begin
            s_axi_rdata <= {24'h000000, rd_byte};
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // software_lcd_pin_driver

// file: lcd_pin_map.vh
// register offsets, field positions and reset values of the lcd pin driver
`ifndef LCD_PIN_MAP_VH
`define LCD_PIN_MAP_VH
`define PHASE_BIAS_OFS 5'h00
`define COMMON_ROLE_OFS 5'h04
`define SEG_EN_LOW_OFS 5'h08
`define SEG_EN_MID_OFS 5'h0c
`define SEG_EN_HIGH_OFS 5'h10
`define PORT_DATA_LO_OFS 5'h14
`define PORT_DATA_HI_OFS 5'h18
`define OSC_CLAIM_OFS 5'h1c
`define REG_RESET 8'h00
`define PHASE_BIT 7
`define BIAS_HI_BIT 6
`define BIAS_LO_BIT 5
`define MASTER_ON_BIT 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define LVL_GND 2'h0
`define LVL_LOW_BIAS 2'h1
`define LVL_HIGH_BIAS 2'h2
`define LVL_SUPPLY 2'h3
`define PIN_COUNT 30
`endif

// file: lcd_glass_model.sv
// passive lcd glass model: one pixel between common pin 0 and segment pin 6
`timescale 1ns/1ps
module lcd_glass_model (
   // pin switch levels
   input wire logic [59:0] pin_level_sel_ff,
   input wire logic [29:0] pin_lcd_active_ff,
   // pixel drive in thirds of supply
   output logic [1:0] pixel_thirds
);
   logic [1:0] lc, ls;
   assign lc = pin_level_sel_ff[1:0];
   assign ls = pin_level_sel_ff[13:12];
   // a pixel only sees a field when both electrodes are driven
   assign pixel_thirds = (pin_lcd_active_ff[0] && pin_lcd_active_ff[6]) ?
      ((lc > ls) ? lc - ls : ls - lc) : 2'h0;
endmodule // lcd_glass_model

// file: lcd_pin_checker.sv
// assertion checker for the lcd pin driver
`timescale 1ns/1ps
module lcd_pin_checker (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // bus handshakes
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_awready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata,
   // pin controls
   input logic [59:0] pin_level_sel_ff,
   input logic [29:0] pin_lcd_active_ff,
   input logic bias_divider_on_ff
);
   logic idle_bad, seg_hi, seg_lo;
   always_comb begin
      idle_bad = 1'b0;
      seg_hi = 1'b0;
      seg_lo = 1'b0;
      for (int i = 0; i < 30; i++) begin
         if (!pin_lcd_active_ff[i]) idle_bad |= |pin_level_sel_ff[2*i+:2];
         else if (i > 5) begin
            seg_hi |= pin_level_sel_ff[2*i];
            seg_lo |= !pin_level_sel_ff[2*i];
         end
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
   sequence b_take; s_axi_bvalid && s_axi_bready; endsequence
   sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
   AST_OFF_GROUND:
      assert property (!bias_divider_on_ff |-> pin_lcd_active_ff == 30'h0 &&
         pin_level_sel_ff == 60'h0) else $error("pins not grounded while off");
   AST_IDLE_GROUND:
      assert property (!idle_bad) else $error("inactive pin not grounded");
   AST_SEG_PHASE:
      assert property (!(seg_hi && seg_lo)) else $error("segments disagree on phase");
   AST_B_HOLD:
      assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
         else $error("write response dropped");
   AST_B_DONE:
      assert property (b_take |=> !s_axi_bvalid) else $error("write response repeated");
   AST_R_HOLD:
      assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("read data dropped");
   AST_R_ANSWER:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
         else $error("read answer late");
   AST_AW_BLOCK:
      assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken early");
   AST_RESET_QUIET:
      assert property ($rose(aresetn) |-> !bias_divider_on_ff && pin_level_sel_ff == 60'h0)
         else $error("outputs busy after reset");
endmodule // lcd_pin_checker
bind software_lcd_pin_driver lcd_pin_checker lcd_pin_checker_inst (.aclk(aclk),
   .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .pin_level_sel_ff(pin_level_sel_ff), .pin_lcd_active_ff(pin_lcd_active_ff),
   .bias_divider_on_ff(bias_divider_on_ff));

// file: tb_software_lcd_pin_driver.sv
// testbench for the software lcd pin driver
`timescale 1ns/1ps
module tb_software_lcd_pin_driver;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [4:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   wire awready, wready, bvalid, arready, rvalid, div;
   wire [1:0] bresp, rresp, code, pixel;
   wire [31:0] rdata;
   wire [59:0] lvl;
   wire [29:0] act;
   integer bad_count = 0, checks = 0, seed = 32'hb25c, cyc = 0, k;
   logic [33:0] q[$];
   logic [7:0] c0, c1;
   logic [23:0] se;
   logic [29:0] d;
   logic [89:0] e;
   initial forever #2 aclk = ~aclk;
   software_lcd_pin_driver software_lcd_pin_driver_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_level_sel_ff(lvl), .pin_lcd_active_ff(act),
      .bias_divider_on_ff(div), .bias_current_code_ff(code));
   lcd_glass_model lcd_glass_model_inst (.pin_level_sel_ff(lvl), .pin_lcd_active_ff(act),
      .pixel_thirds(pixel));
   task chk(input [95:0] x, input [95:0] y, input string n);
      checks = checks + 1;
      if (x !== y) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", n, x, y);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wr(input [4:0] a, input [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 1;
      @(posedge aclk);
      chk(96'h0, bresp, "bresp");
      bready <= 0;
   endtask
   task rd(input [4:0] a, input [31:0] v);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      q.push_back({2'h0, v});
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge aclk);
      rready <= 1;
      @(posedge aclk);
      rready <= 0;
   endtask
   function automatic [89:0] expect_pins(input [7:0] a, b, input [23:0] s,
      input [29:0] v, input osc);
      reg [29:0] en;
      reg [59:0] l;
      reg com;
      en = {s, b[7:6], a[3:0]} & {30{a[4]}};
      if (osc) en[15:14] = 2'b00;
      for (int i = 0; i < 30; i++) begin
         com = (i < 6) ? !b[i % 6] : 1'b0;
         l[2*i+:2] = !en[i] ? 2'h0 : (com ^ a[7]) ? (v[i] ? 2'h3 : 2'h1) :
            (v[i] ? 2'h0 : 2'h2);
      end
      return {en, l};
   endfunction
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (rvalid && rready) begin
         if (q.size() == 0) chk(96'h1, 96'h0, "read queue");
         else chk(q.pop_front(), {rresp, rdata}, "read data");
      end
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      for (k = 0; k < 5; k++) rd(4 * k, 0);
      for (k = 0; k < 8; k++) begin
         c0 = $random(seed);
         c0[7:4] = {k[0], k[2:1], k != 3};
         c1 = $random(seed);
         se = $random(seed);
         d = $random(seed);
         wr(0, c0);
         wr(4, c1);
         wr(8, se[7:0]);
         wr(12, se[15:8]);
         wr(16, se[23:16]);
         wr(20, d[15:0]);
         wr(24, d[29:16]);
         wr(28, k[2]);
         e = expect_pins(c0, c1, se, d, k[2]);
         @(posedge aclk);
         #1;
         chk(e[59:0], lvl, "levels");
         chk(e[89:60], act, "active");
         chk({c0[4], c0[6:5]}, {div, code}, "bias");
         chk((e[60] && e[66]) ? ((e[1:0] > e[13:12]) ? e[1:0] - e[13:12] :
            e[13:12] - e[1:0]) : 2'h0, pixel, "pixel");
         rd(0, c0);
         rd(4, c1);
      end
      tally_and_finish;
   end
endmodule // tb_software_lcd_pin_driver
